// file: hw/cdt_timer_unit.sv
// cdt_timer_unit: four countdown timers with interrupt logic on AXI4-Lite
`timescale 1ns/1ps
//
// Contract
// - four countdown timers, each tied to an audio channel and divide value
// - a start strobe write loads every timer from its divide value and runs
// - a running timer 1, 2 or 4 reaching zero raises that timer's interrupt request
// - only timers 1, 2 and 4 have interrupt paths; timer 3 has none
// - enable mask bits 0, 1, 2 gate interrupts of timers 1, 2, 4
// - any data written to the start strobe triggers; the value is ignored
module cdt_timer_unit
	import cdt_pkg::*;
#(
	parameter int unsigned BASE_DIV = BASE_DIV_DEF,
	parameter int unsigned ALT_DIV  = ALT_DIV_DEF
) (
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic [ADDR_W-1:0]              s_axi_awaddr,
	input  wire logic [2:0]                     s_axi_awprot,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [DATA_W-1:0]              s_axi_wdata,
	input  wire logic [DATA_W/8-1:0]            s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [ADDR_W-1:0]              s_axi_araddr,
	input  wire logic [2:0]                     s_axi_arprot,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [DATA_W-1:0]                   s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	output logic [NUM_TIMERS-1:0][BYTE_W-1:0]   channel_control,
	output logic                                irq
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic                               aw_have;
		logic [15:0]                        aw_idx;
		logic                               w_have;
		logic [DATA_W-1:0]                  w_data;
		logic                               w_lane0;
		logic                               awready;
		logic                               wready;
		logic                               bvalid;
		logic [1:0]                         bresp;
		logic                               arready;
		logic                               rvalid;
		logic [DATA_W-1:0]                  rdata;
		logic [1:0]                         rresp;
		logic [NUM_TIMERS-1:0][BYTE_W-1:0]  divide;
		logic [NUM_TIMERS-1:0][BYTE_W-1:0]  chan_ctrl;
		logic [BYTE_W-1:0]                  clk_sel;
		logic                               start;
		logic [IRQ_BITS-1:0]                status;
		logic [IRQ_BITS-1:0]                mask;
		logic                               irq;
		logic [DIV_W-1:0]                   fast_cnt;
		logic [DIV_W-1:0]                   base_cnt;
		logic [DIV_W-1:0]                   alt_cnt;
		logic                               fast_tick;
		logic                               base_tick;
		logic                               alt_tick;
	} cdt_state_t;

	cdt_state_t state_ff;
	cdt_state_t nxt_state;

	logic [NUM_TIMERS-1:0]              tick_sel;
	logic [NUM_TIMERS-1:0]              zero_evt;

	// register index carried in address bits above the word offset
	function automatic logic [15:0] addr_index(input logic [ADDR_W-1:0] a);
		addr_index = a[17:2];
	endfunction : addr_index

	// channel number of a divide or channel-control index, else out of range
	function automatic logic [2:0] chan_of(input logic [15:0] idx);
		logic [15:0] off;
		off = idx - IDX_TIMER1_DIVIDE;
		if (idx >= IDX_TIMER1_DIVIDE && idx <= IDX_CHAN4_CTRL) begin
			chan_of = {1'b0, off[2:1]};
		end else begin
			chan_of = 3'h4;
		end
	endfunction : chan_of

	////////////////////////////////////////////////////////////////////////
	// timers

	localparam logic [DIV_W-1:0] FAST_LAST = DIV_W'(FAST_DIV - 1);
	localparam logic [DIV_W-1:0] BASE_LAST = DIV_W'(BASE_DIV - 1);
	localparam logic [DIV_W-1:0] ALT_LAST  = DIV_W'(ALT_DIV - 1);

	// the count clock of each timer follows the clock select register
	always_comb begin
		logic slow_tick;
		slow_tick = state_ff.clk_sel[CSEL_SLOW_BASE] ? state_ff.alt_tick
		                                             : state_ff.base_tick;
		for (int i = 0; i < NUM_TIMERS; i++) begin
			tick_sel[i] = slow_tick;
		end
		if (state_ff.clk_sel[CSEL_T1_FAST]) begin
			tick_sel[0] = state_ff.fast_tick;
		end
		if (state_ff.clk_sel[CSEL_T3_FAST]) begin
			tick_sel[2] = state_ff.fast_tick;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_TIMERS; g++) begin : g_timer
			cdt_timer_chan u_chan (
				.aclk         (aclk),
				.aresetn      (aresetn),
				.load         (state_ff.start),
				.tick         (tick_sel[g]),
				.divide_value (state_ff.divide[g]),
				.zero_evt     (zero_evt[g]),
				.count        ()
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic                aw_go;
		logic                w_go;
		logic                ar_go;
		logic                do_wr;
		logic [15:0]         ridx;
		logic [2:0]          wch;
		logic [2:0]          rch;
		logic [IRQ_BITS-1:0] evt;
		logic [IRQ_BITS-1:0] clr;

		nxt_state       = state_ff;
		nxt_state.start = 1'b0;
		aw_go = s_axi_awvalid && state_ff.awready;
		w_go  = s_axi_wvalid && state_ff.wready;
		ar_go = s_axi_arvalid && state_ff.arready;
		ridx  = addr_index(s_axi_araddr);
		rch   = chan_of(ridx);
		clr   = RST_IRQ;

		// rate dividers: one-cycle enable pulses
		nxt_state.fast_tick = (state_ff.fast_cnt == FAST_LAST);
		nxt_state.fast_cnt  = nxt_state.fast_tick ? '0
		                      : state_ff.fast_cnt + DIV_W'(1);
		nxt_state.base_tick = (state_ff.base_cnt == BASE_LAST);
		nxt_state.base_cnt  = nxt_state.base_tick ? '0
		                      : state_ff.base_cnt + DIV_W'(1);
		nxt_state.alt_tick  = (state_ff.alt_cnt == ALT_LAST);
		nxt_state.alt_cnt   = nxt_state.alt_tick ? '0
		                      : state_ff.alt_cnt + DIV_W'(1);

		// write channel: address and data taken in either order
		if (aw_go) begin
			nxt_state.aw_have = 1'b1;
			nxt_state.aw_idx  = addr_index(s_axi_awaddr);
			nxt_state.awready = 1'b0;
		end
		if (w_go) begin
			nxt_state.w_have  = 1'b1;
			nxt_state.w_data  = s_axi_wdata;
			nxt_state.w_lane0 = s_axi_wstrb[0];
			nxt_state.wready  = 1'b0;
		end
		do_wr = state_ff.aw_have && state_ff.w_have && !state_ff.bvalid;
		wch   = chan_of(state_ff.aw_idx);
		if (do_wr) begin
			nxt_state.aw_have = 1'b0;
			nxt_state.w_have  = 1'b0;
			nxt_state.bvalid  = 1'b1;
			nxt_state.bresp   = RESP_OKAY;
			if (state_ff.aw_idx == IDX_START_STROBE) begin
				nxt_state.start = 1'b1;
			end else if (wch < 3'h4) begin
				if (state_ff.w_lane0) begin
					if (state_ff.aw_idx[0]) begin
						// volume field stays with the audio side
						nxt_state.chan_ctrl[wch[1:0]] =
							state_ff.w_data[BYTE_W-1:0];
					end else begin
						nxt_state.divide[wch[1:0]] =
							state_ff.w_data[BYTE_W-1:0];
					end
				end
			end else if (state_ff.aw_idx == IDX_CLOCK_SELECT) begin
				if (state_ff.w_lane0) begin
					nxt_state.clk_sel = state_ff.w_data[BYTE_W-1:0];
				end
			end else if (state_ff.aw_idx == IDX_IRQ_ENABLE_MASK) begin
				if (state_ff.w_lane0) begin
					nxt_state.mask = state_ff.w_data[IRQ_BITS-1:0];
				end
			end else if (state_ff.aw_idx != IDX_IRQ_STATUS) begin
				nxt_state.bresp = RESP_SLVERR;
			end
		end
		if (state_ff.bvalid && s_axi_bready) begin
			nxt_state.bvalid  = 1'b0;
			nxt_state.awready = 1'b1;
			nxt_state.wready  = 1'b1;
		end

		// read channel: one read at a time, answer one cycle after taking
		if (ar_go) begin
			nxt_state.arready = 1'b0;
			nxt_state.rvalid  = 1'b1;
			nxt_state.rdata   = '0;
			nxt_state.rresp   = RESP_OKAY;
			if (ridx == IDX_IRQ_STATUS) begin
				nxt_state.rdata[IRQ_BITS-1:0] = state_ff.status;
				clr = state_ff.status;
			end else if (ridx == IDX_IRQ_ENABLE_MASK) begin
				nxt_state.rdata[IRQ_BITS-1:0] = state_ff.mask;
			end else if (rch < 3'h4 || ridx == IDX_CLOCK_SELECT
			             || ridx == IDX_START_STROBE) begin
				// write-only registers read as zero
				nxt_state.rdata = '0;
			end else begin
				nxt_state.rresp = RESP_SLVERR;
			end
		end
		if (state_ff.rvalid && s_axi_rready) begin
			nxt_state.rvalid  = 1'b0;
			nxt_state.arready = 1'b1;
		end

		// timer 3 has no status bit, so its zero event goes nowhere
		evt = RST_IRQ;
		evt[IRQ_BIT_TIMER1] = zero_evt[0];
		evt[IRQ_BIT_TIMER2] = zero_evt[1];
		evt[IRQ_BIT_TIMER4] = zero_evt[3];
		// an event in the clearing read's cycle is kept: set wins
		nxt_state.status = (state_ff.status & ~clr) | evt;
		// handler readiness is software's affair before unmasking
		nxt_state.irq = |(nxt_state.status & nxt_state.mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff         <= '0;
			state_ff.awready <= 1'b1;
			state_ff.wready  <= 1'b1;
			state_ff.arready <= 1'b1;
			state_ff.clk_sel <= RST_BYTE;
			state_ff.mask    <= RST_IRQ;
			state_ff.status  <= RST_IRQ;
			state_ff.bresp   <= RESP_OKAY;
			state_ff.rresp   <= RESP_OKAY;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign s_axi_awready   = state_ff.awready;
	assign s_axi_wready    = state_ff.wready;
	assign s_axi_bvalid    = state_ff.bvalid;
	assign s_axi_bresp     = state_ff.bresp;
	assign s_axi_arready   = state_ff.arready;
	assign s_axi_rvalid    = state_ff.rvalid;
	assign s_axi_rdata     = state_ff.rdata;
	assign s_axi_rresp     = state_ff.rresp;
	assign channel_control = state_ff.chan_ctrl;
	assign irq             = state_ff.irq;

endmodule : cdt_timer_unit

// file: inc/cdt_pkg.sv
// cdt_pkg: register map, field layout and timing constants of the timer unit
package cdt_pkg;

	localparam int unsigned NUM_TIMERS = 4;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned ADDR_W     = 32;
	localparam int unsigned BYTE_W     = 8;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_TIMER1_DIVIDE   = 16'hD200;
	localparam logic [15:0] IDX_CHAN1_CTRL      = 16'hD201;
	localparam logic [15:0] IDX_TIMER2_DIVIDE   = 16'hD202;
	localparam logic [15:0] IDX_CHAN2_CTRL      = 16'hD203;
	localparam logic [15:0] IDX_TIMER3_DIVIDE   = 16'hD204;
	localparam logic [15:0] IDX_CHAN3_CTRL      = 16'hD205;
	localparam logic [15:0] IDX_TIMER4_DIVIDE   = 16'hD206;
	localparam logic [15:0] IDX_CHAN4_CTRL      = 16'hD207;
	localparam logic [15:0] IDX_CLOCK_SELECT    = 16'hD208;
	localparam logic [15:0] IDX_START_STROBE    = 16'hD209;
	localparam logic [15:0] IDX_IRQ_STATUS      = 16'hD20D;
	localparam logic [15:0] IDX_IRQ_ENABLE_MASK = 16'hD20E;

	// status and mask layout: bit 0 timer 1, bit 1 timer 2, bit 2 timer 4
	localparam int unsigned IRQ_BITS       = 3;
	localparam int unsigned IRQ_BIT_TIMER1 = 0;
	localparam int unsigned IRQ_BIT_TIMER2 = 1;
	localparam int unsigned IRQ_BIT_TIMER4 = 2;

	// clock select fields
	localparam int unsigned CSEL_SLOW_BASE = 0;
	localparam int unsigned CSEL_T3_FAST   = 5;
	localparam int unsigned CSEL_T1_FAST   = 6;

	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [2:0]  RST_IRQ    = 3'h0;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// timing: system clock and the three count rates
	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned FAST_HZ      = 1_790_000;
	localparam int unsigned BASE_HZ      = 64_000;
	localparam int unsigned ALT_HZ       = 15_000;
	localparam int unsigned FAST_DIV     = CLK_HZ / FAST_HZ;
	localparam int unsigned BASE_DIV_DEF = CLK_HZ / BASE_HZ;
	localparam int unsigned ALT_DIV_DEF  = CLK_HZ / ALT_HZ;
	localparam int unsigned DIV_W        = 16;

endpackage : cdt_pkg

// file: hw/cdt_timer_chan.sv
// cdt_timer_chan: one reloadable eight-bit countdown timer
`timescale 1ns/1ps
module cdt_timer_chan
	import cdt_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              load,
	input  wire logic              tick,
	input  wire logic [BYTE_W-1:0] divide_value,
	output logic                   zero_evt,
	output logic [BYTE_W-1:0]      count
);

	typedef struct packed {
		logic              running;
		logic [BYTE_W-1:0] cnt;
		logic              evt;
	} cdt_chan_t;

	cdt_chan_t state_ff;
	cdt_chan_t nxt_state;

	always_comb begin
		nxt_state     = state_ff;
		nxt_state.evt = 1'b0;
		if (load) begin
			nxt_state.running = 1'b1;
			nxt_state.cnt     = divide_value;
		end else if (state_ff.running && tick) begin
			// a divide value of zero or one fires on every tick
			if (state_ff.cnt <= BYTE_W'(1)) begin
				nxt_state.evt = 1'b1;
				nxt_state.cnt = divide_value;
			end else begin
				nxt_state.cnt = state_ff.cnt - BYTE_W'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign zero_evt = state_ff.evt;
	assign count    = state_ff.cnt;

endmodule : cdt_timer_chan

// file: tb/cdt_unit_monitor.sv
// cdt_unit_monitor: bus and interrupt properties of the timer unit
`timescale 1ns/1ps
module cdt_unit_monitor
	import cdt_pkg::*;
(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two cycles after take");
	chk_bresp_code: assert property (s_axi_bvalid |->
		s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
		else $error("bad write response code");
	chk_write_ready: assert property (s_axi_bvalid && s_axi_bready |=>
		s_axi_awready && s_axi_wready && !s_axi_bvalid)
		else $error("write channels not reopened");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read data not one cycle after take");
	chk_read_cause: assert property ($rose(s_axi_rvalid) |->
		$past(s_axi_arvalid && s_axi_arready))
		else $error("read data without request");
	chk_read_ready: assert property (s_axi_rvalid && s_axi_rready |=>
		s_axi_arready && !s_axi_rvalid)
		else $error("read channel not reopened");
	chk_err_data: assert property (s_axi_rvalid &&
		s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
		else $error("error read carries data");
	// status only clears by a read and mask only by a write, so a quiet
	// bus must keep the line up; three cycles cover the register latency
	chk_irq_sticky:
	assert property ((s_axi_awready && s_axi_arready && !s_axi_arvalid)[*3]
		##0 irq |=> irq)
		else $error("interrupt dropped on an idle bus");
endmodule : cdt_unit_monitor

bind cdt_timer_unit cdt_unit_monitor cdt_unit_monitor_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
);

// file: tb/cdt_timer_unit_test.sv
// cdt_timer_unit_test: register-level bench for the countdown timer unit
`timescale 1ns/1ps
module cdt_timer_unit_test
	import cdt_pkg::*;
;
	logic              aclk, aresetn, awvalid, wvalid, bready, arvalid;
	logic              rready, awready, wready, bvalid, arready, rvalid, irq;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	logic [31:0]       chan;
	int                err_count, n_tests, cyc, ts, t0, t1, per;
	int                divs[4] = '{10, 5, 2, 7};
	logic [7:0]        csel[3] = '{8'h00, 8'h01, 8'h40};
	int                rate[3] = '{4, 8, FAST_DIV};

	cdt_timer_unit #(.BASE_DIV(4), .ALT_DIV(8)) cdt_timer_unit_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.channel_control(chan), .irq(irq)
	);

	always #5 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// the bench watchdog bounds every wait below
	task automatic wr(input logic [15:0] idx, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= {14'h0, idx, 2'h0};
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr

	task automatic rd(input logic [15:0] idx, input logic [31:0] ed,
		input logic [31:0] m, input logic [1:0] er);
		@(posedge aclk);
		araddr <= {14'h0, idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rready <= 1'b0;
		chk(rdata & m, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rd

	// waits until the line is up; callers clear status first, since a
	// sticky bit left from an earlier event would hold the line up and end the wait at once
	task automatic wirq(output int t);
		while (irq !== 1'b1) @(posedge aclk);
		t = cyc;
	endtask : wirq

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		end_sim();
	end

	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{err_count, n_tests, cyc} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		chk(chan, 32'h0);
		rd(IDX_IRQ_STATUS, 32'h0, '1, RESP_OKAY);
		rd(IDX_TIMER1_DIVIDE, 32'h0, '1, RESP_OKAY);
		rd(16'h0123, 32'h0, '1, RESP_SLVERR);
		wr(16'h0123, 32'h5, 4'hF, RESP_SLVERR);
		$display("test reset and map done");
		for (int i = 0; i < 4; i++)
			wr(IDX_CHAN1_CTRL + 16'(2 * i), 32'hA0 + i, 4'h1, RESP_OKAY);
		wr(IDX_CHAN1_CTRL, 32'h55, 4'h0, RESP_OKAY);
		@(posedge aclk);
		chk(chan, 32'hA3A2A1A0);
		$display("test channel control done");
		for (int i = 0; i < 4; i++)
			wr(IDX_TIMER1_DIVIDE + 16'(2 * i), divs[i], 4'h1, RESP_OKAY);
		wr(IDX_START_STROBE, 32'hFFFFFFFF, 4'h0, RESP_OKAY);
		repeat (100) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		rd(IDX_IRQ_STATUS, 32'h7, '1, RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			wr(IDX_IRQ_ENABLE_MASK, 32'h1 << i, 4'hF, RESP_OKAY);
			rd(IDX_IRQ_STATUS, 32'h0, 32'h0, RESP_OKAY);
			wirq(t0);
			rd(IDX_IRQ_STATUS, 32'h1 << i, 32'h1 << i, RESP_OKAY);
		end
		$display("test interrupt gating done");
		wr(IDX_IRQ_ENABLE_MASK, 32'h1, 4'hF, RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			per = divs[0] * rate[i];
			wr(IDX_CLOCK_SELECT, {24'h0, csel[i]}, 4'h1, RESP_OKAY);
			wr(IDX_START_STROBE, 32'h0, 4'hF, RESP_OKAY);
			ts = cyc;
			// a bit left from the old count would hold the line up
			rd(IDX_IRQ_STATUS, 32'h0, 32'h0, RESP_OKAY);
			wirq(t0);
			chk(32'(t0 - ts >= per - rate[i] && t0 - ts <= per + 4), 1);
			rd(IDX_IRQ_STATUS, 32'h1, 32'h1, RESP_OKAY);
			wirq(t1);
			chk(32'(t1 - t0), 32'(per));
		end
		$display("test periodic reload done");
		end_sim();
	end
endmodule : cdt_timer_unit_test
